// File: irq_consts.svh
// Offsets, field values, vectors and timing counts of the interrupt controller.
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
`define REG_CTRL 12'h000
`define REG_PEND 12'h004
`define REG_ACTV 12'h008
`define REG_STAT 12'h00c
`define REG_SRC 12'h010
`define REG_MASK 12'h014
`define CTRL_GIE 0
`define CTRL_DIS 1
`define CTRL_RTI 2
`define CTRL_SLEEP 3
`define MASK_RESET 8'hde
`define RESET_OPCODE 8'hc1
`define RESET_VECTOR 12'h008
`define MC_CLOCKS 2
`define LAT_MIN_MC 3
`define LAT_MAX_MC 5
`endif

// File: irq_pkg.sv
// Types shared by the interrupt controller.
package irq_pkg;
  typedef enum logic [1:0] {
    st_reset,
    st_run,
    st_ack
  } core_state_t;
endpackage

// File: irq_controller.sv
// Eight-level prioritised interrupt controller with master reset, AXI4-Lite register access.
// Contract
// - eight levels, 8-bit pending and active registers
// - latch requests every non-I/O machine cycle
// - signal only without higher active level
// - acknowledge cycle: short call, push PC
// - return clears pending/active bits, pops PC
// - disabled: latch requests, defer service
// - repeat request merges into pending bit
// - latency three to five machine cycles
// - level seven highest; fixed vectors
// - per-level short-call acknowledge opcodes; here levels 3 and 4 share E8h
// - fixed source mapping; levels 0,5 software
// - hardware sources maskable per level; sources sharing a level share one mask bit
// - software interrupt writes pending register
// - master reset unmaskable, several causes
// - master reset clears flag, pending, active
// - reset: I/O bus reset, ports input
// - reset release: opcode C1h to 008h
// - machine cycle is two clocks
// - enable flag: disable clears, enable/sleep sets
`timescale 1ns/1ns
`include "irq_consts.svh"
module irq_controller #(
  parameter int LEVELS = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Master reset causes, asynchronous pins.
  input wire logic por_req,
  input wire logic brownout_req,
  input wire logic watchdog_req,
  input wire logic clk_supervisor_req,
  // Hardware interrupt sources, asynchronous pins.
  input wire logic port5_pin2,
  input wire logic port5_pin3,
  input wire logic timer1_irq,
  input wire logic sync_serial_iface_irq,
  input wire logic port4_pin0,
  input wire logic port4_pin3,
  input wire logic timer2_irq,
  input wire logic port5_pin0,
  input wire logic port5_pin1,
  input wire logic voltage_monitor_irq_level,
  // Core sequencer side.
  input wire logic io_cycle,
  output logic irq_signal,
  output logic ack_strobe,
  output logic [7:0] ack_opcode,
  output logic [11:0] ack_vector,
  output logic [2:0] ack_level,
  output logic io_bus_reset,
  output logic ports_input,
  output logic mc_tick,
  // AXI4-Lite slave.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [11:0] VEC [8] = '{12'h040, 12'h080, 12'h0c0, 12'h100, 12'h140, 12'h180, 12'h1c0, 12'h1e0};
  localparam logic [7:0] OPC [8] = '{8'hc8, 8'hd0, 8'hd8, 8'he8, 8'he8, 8'hf0, 8'hf8, 8'hfc};

  function automatic logic [3:0] top_level(input logic [7:0] v);
    top_level = 4'h8;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        top_level = 4'(i);
      end
    end
  endfunction

  // Two-flop synchronisers for every pin input.
  logic [13:0] sync1, sync2, prev;
  wire logic [13:0] pins = {clk_supervisor_req, watchdog_req, brownout_req, por_req, voltage_monitor_irq_level,
    port5_pin1, port5_pin0, timer2_irq, port4_pin3, port4_pin0, sync_serial_iface_irq, timer1_irq, port5_pin3,
    port5_pin2};
  always_ff @(posedge aclk) begin
    sync1 <= pins;
    sync2 <= sync1;
    prev <= sync2;
  end

  wire logic master_reset = !aresetn || (|sync2[13:10]);

  logic gie, next_gie;
  logic [7:0] pend, next_pend, actv, next_actv, mask, next_mask;
  logic phase, next_phase;
  irq_pkg::core_state_t state, next_state;
  logic [3:0] sel, next_sel;
  logic rti_req, next_rti_req, swi_req, next_swi_req;
  logic [7:0] swi_val, next_swi_val;
  logic [7:0] ack_op_q, next_ack_op;
  logic [11:0] ack_vec_q, next_ack_vec;
  logic [2:0] ack_lvl_q, next_ack_lvl;
  logic ack_q, next_ack;
  logic dis_req, en_req, next_dis_req, next_en_req;

  // Edge events on port pins are held until the next sampling cycle, so a one-clock edge is never missed.
  logic [9:0] edge_hold, next_edge_hold;
  wire logic [9:0] edges = (sync2[9:0] ^ prev[9:0]) | edge_hold;
  logic [7:0] hw_req;
  always_comb begin
    next_edge_hold = (phase && !io_cycle) ? 10'h000 : edges;
    hw_req = 8'h00;
    hw_req[1] = (edges[0] & mask[1]) | (edges[1] & mask[1]);
    hw_req[2] = sync2[2] & mask[2];
    hw_req[3] = (sync2[3] | edges[4] | edges[5]) & mask[3];
    hw_req[4] = sync2[6] & mask[4];
    hw_req[6] = (edges[7] | edges[8]) & mask[6];
    hw_req[7] = sync2[9] & mask[7];
  end

  wire logic [7:0] blocked_pend = pend & ~actv;
  wire logic [3:0] top_pend = top_level(blocked_pend);
  wire logic [3:0] top_actv = top_level(actv);
  wire logic can_irq = (top_pend != 4'h8) && (top_actv == 4'h8 || top_pend > top_actv);

  always_comb begin
    next_phase = ~phase;
    next_pend = pend;
    next_actv = actv;
    next_gie = gie;
    next_state = state;
    next_sel = sel;
    next_ack = 1'b0;
    next_ack_op = ack_op_q;
    next_ack_vec = ack_vec_q;
    next_ack_lvl = ack_lvl_q;
    // The return clear comes first, so a request arriving in the same cycle is kept.
    if (rti_req && top_actv != 4'h8) begin
      next_pend[top_actv[2:0]] = 1'b0;
      next_actv[top_actv[2:0]] = 1'b0;
    end
    if (phase && !io_cycle) begin
      next_pend = next_pend | hw_req;
    end
    if (swi_req) begin
      next_pend = next_pend | swi_val;
    end
    if (dis_req) begin
      next_gie = 1'b0;
    end else if (en_req) begin
      next_gie = 1'b1;
    end
    case (state)
      irq_pkg::st_reset: begin
        next_state = irq_pkg::st_run;
        next_ack = 1'b1;
        next_ack_op = `RESET_OPCODE;
        next_ack_vec = `RESET_VECTOR;
        next_ack_lvl = 3'h0;
      end
      irq_pkg::st_run: begin
        if (phase && can_irq && gie) begin
          next_state = irq_pkg::st_ack;
          next_sel = top_pend;
        end
      end
      irq_pkg::st_ack: begin
        next_state = irq_pkg::st_run;
        next_actv[sel[2:0]] = 1'b1;
        next_ack = 1'b1;
        next_ack_op = OPC[sel[2:0]];
        next_ack_vec = VEC[sel[2:0]];
        next_ack_lvl = sel[2:0];
      end
      default: next_state = irq_pkg::st_reset;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (master_reset) begin
      gie <= 1'b0;
      pend <= 8'h00;
      actv <= 8'h00;
      phase <= 1'b0;
      state <= irq_pkg::st_reset;
      sel <= 4'h0;
      edge_hold <= 10'h000;
      ack_q <= 1'b0;
      ack_op_q <= 8'h00;
      ack_vec_q <= 12'h000;
      ack_lvl_q <= 3'h0;
    end else begin
      gie <= next_gie;
      pend <= next_pend;
      actv <= next_actv;
      phase <= next_phase;
      state <= next_state;
      sel <= next_sel;
      edge_hold <= next_edge_hold;
      ack_q <= next_ack;
      ack_op_q <= next_ack_op;
      ack_vec_q <= next_ack_vec;
      ack_lvl_q <= next_ack_lvl;
    end
  end

  assign irq_signal = can_irq;
  assign ack_strobe = ack_q;
  assign ack_opcode = ack_op_q;
  assign ack_vector = ack_vec_q;
  assign ack_level = ack_lvl_q;
  assign io_bus_reset = master_reset || state == irq_pkg::st_reset;
  assign ports_input = io_bus_reset;
  assign mc_tick = phase;

  // AXI4-Lite slave: one write and one read at a time.
  logic aw_got, w_got, bvalid_q, rvalid_q;
  logic next_aw_got, next_w_got, next_bvalid, next_rvalid;
  logic [11:0] aw_q, next_aw;
  logic [31:0] w_q, next_w, rdata_q, next_rdata;
  logic [1:0] bresp_q, next_bresp, rresp_q, next_rresp;
  assign s_axi_awready = !aw_got && !bvalid_q;
  assign s_axi_wready = !w_got && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw = aw_q;
    next_w = w_q;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    next_mask = mask;
    next_swi_req = 1'b0;
    next_swi_val = swi_val;
    next_rti_req = 1'b0;
    next_dis_req = 1'b0;
    next_en_req = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
    end
    if (aw_got && w_got) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      case ({aw_q[11:2], 2'b00})
        `REG_CTRL: begin
          next_en_req = w_q[`CTRL_GIE] | w_q[`CTRL_SLEEP];
          next_dis_req = w_q[`CTRL_DIS];
          next_rti_req = w_q[`CTRL_RTI];
        end
        `REG_PEND: begin
          next_swi_req = 1'b1;
          next_swi_val = w_q[7:0];
        end
        `REG_MASK: next_mask = w_q[7:0];
        `REG_ACTV, `REG_STAT, `REG_SRC: next_bresp = 2'b00;
        default: next_bresp = 2'b10;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      case ({s_axi_araddr[11:2], 2'b00})
        `REG_CTRL: next_rdata = {31'h0000_0000, gie};
        `REG_PEND: next_rdata = {24'h00_0000, pend};
        `REG_ACTV: next_rdata = {24'h00_0000, actv};
        `REG_STAT: next_rdata = {24'h00_0000, irq_signal, state == irq_pkg::st_ack, 2'b00, top_pend};
        `REG_SRC: next_rdata = {24'h00_0000, hw_req};
        `REG_MASK: next_rdata = {24'h00_0000, mask};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'b10;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
      mask <= `MASK_RESET;
      swi_req <= 1'b0;
      swi_val <= 8'h00;
      rti_req <= 1'b0;
      dis_req <= 1'b0;
      en_req <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_q <= next_aw;
      w_q <= next_w;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
      mask <= next_mask;
      swi_req <= next_swi_req;
      swi_val <= next_swi_val;
      rti_req <= next_rti_req;
      dis_req <= next_dis_req;
      en_req <= next_en_req;
    end
  end
endmodule

// File: irq_chk.sv
// Concurrent checks on the interrupt controller's core side.
`timescale 1ns/1ns
module irq_chk #(
  parameter int LEVELS = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Observed ports.
  input wire logic watchdog_req,
  input wire logic ack_strobe,
  input wire logic [7:0] ack_opcode,
  input wire logic [11:0] ack_vector,
  input wire logic [2:0] ack_level,
  input wire logic io_bus_reset,
  input wire logic ports_input,
  input wire logic mc_tick
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  localparam logic [7:0] OPC [8] = '{8'hc8, 8'hd0, 8'hd8, 8'he8, 8'he8, 8'hf0, 8'hf8, 8'hfc};
  wire lvl_ack = ack_strobe && ack_opcode != 8'hc1;
  property p_pulse; ack_strobe |=> !ack_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("ack strobe too long");
  property p_boot; $rose(aresetn) |=> ack_strobe && ack_opcode == 8'hc1 && ack_vector == 12'h008; endproperty
  a_boot: assert property (p_boot) else $error("no reset call");
  property p_vec; lvl_ack |-> ack_vector == (ack_level == LEVELS - 1 ? 12'h1e0 : {3'h0, ack_level + 3'd1, 6'h0}); endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_opc; lvl_ack |-> ack_opcode == OPC[ack_level]; endproperty
  a_opc: assert property (p_opc) else $error("wrong opcode");
  property p_rel; $rose(aresetn) |-> io_bus_reset && ports_input; endproperty
  a_rel: assert property (p_rel) else $error("io reset not held");
  property p_tick; !io_bus_reset |=> mc_tick != $past(mc_tick); endproperty
  a_tick: assert property (p_tick) else $error("machine cycle not two clocks");
  property p_wd_on; $rose(watchdog_req) |-> ##[1:6] io_bus_reset && ports_input; endproperty
  a_wd_on: assert property (p_wd_on) else $error("master reset not applied");
  property p_wd_call; $fell(watchdog_req) |-> ##[1:8] ack_strobe && ack_opcode == 8'hc1; endproperty
  a_wd_call: assert property (p_wd_call) else $error("no call after master reset");
endmodule

// File: core_model.sv
// Far-side model: core I/O cycle marker and interrupt source pins.
`timescale 1ns/1ns
module core_model (
  // Clock and commands.
  input wire logic aclk,
  input wire logic [9:0] req,
  input wire logic busy,
  input wire logic tick,
  // Toward the controller.
  output logic [9:0] pins = 10'h0,
  output logic io_cycle = 1'b0
);
  always @(posedge aclk) begin
    pins <= req;
    // I/O cycles alternate with plain machine cycles and change only at a machine-cycle boundary.
    if (tick) begin
      io_cycle <= busy & ~io_cycle;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ns
`include "irq_consts.svh"
module testbench;
  logic aclk = 0;
  logic aresetn = 0;
  logic io_busy = 0;
  logic [3:0] rst_src = 0;
  logic [9:0] src_req = 0;
  logic [9:0] pins;
  logic io_cycle, irq_signal, ack_strobe, io_bus_reset, ports_input, mc_tick;
  logic [7:0] ack_opcode, m, v;
  logic [11:0] ack_vector;
  logic [2:0] ack_level;
  wire por_req, brownout_req, watchdog_req, clk_supervisor_req;
  wire port5_pin2, port5_pin3, timer1_irq, sync_serial_iface_irq, port4_pin0;
  wire port4_pin3, timer2_irq, port5_pin0, port5_pin1, voltage_monitor_irq_level;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fails = 0, comparisons = 0, resets = 0, lat, h;
  int rom_bank_register = 0;
  int bank_stack[$];
  integer seed = 32'hb68465e8;
  logic [2:0] q[$];
  localparam bit [29:0] MAP = {3'd7, 3'd6, 3'd6, 3'd4, 3'd3, 3'd3, 3'd3, 3'd2, 3'd1, 3'd1};
  assign {por_req, brownout_req, watchdog_req, clk_supervisor_req} = rst_src;
  assign {voltage_monitor_irq_level, port5_pin1, port5_pin0, timer2_irq, port4_pin3, port4_pin0,
    sync_serial_iface_irq, timer1_irq, port5_pin3, port5_pin2} = pins;
  irq_controller dut (.*);
  core_model far (.aclk(aclk), .req(src_req), .busy(io_busy), .tick(mc_tick), .pins(pins), .io_cycle(io_cycle));
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ack_strobe === 1'b1 && ack_opcode === 8'hc1) resets++;
    else if (ack_strobe === 1'b1) q.push_back(ack_level);
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [11:0] a, input [31:0] wd);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task rd(input [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task rchk(input string n, input [11:0] a, input [7:0] e);
    rd(a);
    chk(n, e, d[7:0]);
  endtask
  task wack(input [2:0] l);
    lat = 0;
    while (q.size() == 0 && lat < 60) begin
      @(negedge aclk);
      lat++;
    end
    chk("ack_level", l, q.size() > 0 ? q.pop_front() : 3'bx);
  endtask
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    chk("reset_calls", 1, resets);
    chk("reset_vector", `RESET_VECTOR, ack_vector);
    rchk("ctrl", `REG_CTRL, 0);
    rchk("mask", `REG_MASK, `MASK_RESET);
    rchk("active", `REG_ACTV, 0);
    rd(12'h100);
    chk("rresp", 2'b10, r);
    chk("rdata", 0, d);
    v = $random(seed);
    m = v | 8'h81;
    wr(`REG_PEND, m);
    v = $random(seed);
    wr(`REG_PEND, v);
    m = m | v;
    repeat (10) @(posedge aclk);
    chk("acks_off", 0, q.size());
    chk("irq_signal", 1, irq_signal);
    rchk("status", `REG_STAT, 8'h87);
    rchk("pend", `REG_PEND, m);
    wr(`REG_CTRL, 1);
    while (m != 0) begin
      for (int i = 0; i < 8; i++) begin
        if (m[i]) h = i;
      end
      wack(h[2:0]);
      bank_stack.push_back(rom_bank_register);
      rom_bank_register = h;
      rchk("active", `REG_ACTV, 8'h1 << h);
      chk("irq_blocked", 0, irq_signal);
      rom_bank_register = bank_stack.pop_back();
      wr(`REG_CTRL, 5);
      m[h] = 1'b0;
    end
    rchk("pend", `REG_PEND, 0);
    chk("irq_idle", 0, irq_signal);
    for (int s = 0; s < 10; s++) begin
      src_req[s] <= 1'b1;
      wack(MAP[s*3+:3]);
      chk("latency_ok", 1, lat <= `MC_CLOCKS * `LAT_MAX_MC + 4);
      @(posedge aclk);
      src_req[s] <= 1'b0;
      repeat (10) @(posedge aclk);
      wr(`REG_CTRL, 5);
      rchk("pend", `REG_PEND, 0);
    end
    io_busy <= 1'b1;
    wr(`REG_MASK, 8'hda);
    src_req[2] <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("acks_masked", 0, q.size());
    rchk("pend", `REG_PEND, 0);
    rchk("src", `REG_SRC, 0);
    wr(`REG_MASK, `MASK_RESET);
    wack(3'd2);
    @(posedge aclk);
    src_req[2] <= 1'b0;
    repeat (10) @(posedge aclk);
    wr(`REG_CTRL, 5);
    rchk("pend", `REG_PEND, 0);
    for (int c = 0; c < 4; c++) begin
      wr(`REG_CTRL, 2);
      wr(`REG_PEND, 8'h21);
      rst_src[c] <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("io_bus_reset", 1, io_bus_reset);
      rst_src[c] <= 1'b0;
      repeat (8) @(posedge aclk);
      chk("reset_calls", c + 2, resets);
      rchk("ctrl", `REG_CTRL, 0);
      rchk("pend", `REG_PEND, 0);
    end
    results;
  end
  initial begin
    #2000000;
    fails++;
    results;
  end
endmodule
bind irq_controller irq_chk #(.LEVELS(LEVELS)) chk (.*);
